//--- design/pscr_map.vh
// pscr_map.vh: register map, field positions and reset values for the synth config bank
// assumes: included by the config bank module only
`ifndef PSCR_MAP_VH
`define PSCR_MAP_VH

// ************************************************************
// frame layout
// ************************************************************
`define PSCR_FRAME_BITS     32
`define PSCR_DATA_BITS      27
`define PSCR_ADDR_MSB       30
`define PSCR_ADDR_LSB       27
`define PSCR_MODE_BIT       31

// ************************************************************
// register addresses
// ************************************************************
`define PSCR_ADDR_MASTER    4'h0
`define PSCR_ADDR_REFLEAK   4'h3
`define PSCR_ADDR_LOCKOSC   4'h4
`define PSCR_ADDR_LOWPWR    4'h5
`define PSCR_ADDR_CALMOD    4'h6
`define PSCR_ADDR_FASTLOCK  4'h7

// ************************************************************
// field positions and calibrator divider maximum
// ************************************************************
`define PSCR_SHADOW_BIT     26
`define PSCR_PD_BIT         25
`define PSCR_DETECTOR_DELAY_VALUE_MSB    20
`define PSCR_DETECTOR_DELAY_VALUE_LSB    19
`define PSCR_CALDIV_MAX     9'h1ff

// ************************************************************
// reset values
// ************************************************************
`define PSCR_RST_REFLEAK    27'h0000001
`define PSCR_RST_LOCKOSC    27'h0000100
`define PSCR_RST_ZERO       27'h0000000

`endif

//--- design/pscr_config_bank.v
// pscr_config_bank.v: serial-programmed configuration register bank of the synthesizer
// assumes: serial clock, data and latch lines come asynchronously from the host;
// core_clk_i at 125 MHz samples them, so the serial clock must stay below ~30 MHz
`include "pscr_map.vh"

// Summary of operation
// (RL1) with shadow bit set, written data waits until master register is written; here only the reference/leakage register does so
// (RL2) power-down bit turns off all blocks except regulators; here it forces off only the internal oscillator, external buffer and RF output
// (RL3) leakage code scales linearly, 10 or 20 uA step, zero gives none
// (RL4) leakage direction: zero sinks current, one sources current
// (RL5) down-split enable turns on pulse current sized by master delay field
// (RL6) delay mode: none, feedback path, reference path; code 11 reserved
// (RL7) reference path: direct, doubled, divide by two, divide by four
// (RL8) reference divider field sets ratio directly, host writes 1 to 8191
// (RL9) external oscillator enable powers internal oscillators down
// (RL10) host limits amplitude code to 010 on low core supply
// (RL11) host sets calibrator mode bit by supply and frequency
// (RL12) gain compensation active unless its disable bit is one
// (RL13) polarity bit selects standard or inverted detector polarity
// (RL14) reference buffer: differential, crystal, single ended; 00 reserved
// (RL15) mute enable turns RF outputs off while loop unlocked
// (RL16) lock indicator polarity bit inverts the indicator level
// (RL17) lock window is 2 ns times code plus one
// (RL18) lock count codes map to 4,8,16,64,256,1024,2048,4096
// (RL19) three low-power bits for output buffer, demux, reference buffer
// (RL20) modulator order 3,2,1,4 by code; separate dither enable bit
// (RL21) precharge slots one to four; accuracy bit adds two slots
// (RL22) calibrator divider 1 to 511; zero acts as 511
// (RL23) frame is mode bit, four address bits, 27 data bits
// (RL24) data captured on rising serial clock edge
// (RL25) non-shadowed register applies its data at latch enable
module pscr_config_bank
(
	input  wire        core_clk_i,
	input  wire        reset_i,
	input  wire        ser_clk_i,
	input  wire        ser_data_i,
	input  wire        latch_en_i,
	input  wire        loop_locked_i,
	output reg  [26:0] master_register_o,
	output reg  [26:0] reference_and_leakage_control_o,
	output reg  [26:0] lock_and_oscillator_settings_o,
	output reg  [26:0] low_power_control_o,
	output reg  [26:0] calibrator_and_modulator_control_o,
	output reg  [26:0] fast_lock_and_output_pin_control_o,
	output reg         chip_power_down_o,
	output reg  [9:0]  leak_current_ua_o,
	output reg         leak_source_o,
	output reg  [1:0]  down_split_level_o,
	output reg         delay_feedback_o,
	output reg         delay_reference_o,
	output reg  [2:0]  ref_path_mult_o,
	output reg  [12:0] ref_divider_o,
	output reg         internal_osc_enable_o,
	output reg         external_buffer_enable_o,
	output reg         gain_compensation_o,
	output reg         detector_inverted_o,
	output reg  [1:0]  reference_buffer_select_o,
	output reg         rf_output_enable_o,
	output reg         lock_indicator_o,
	output reg  [4:0]  lock_window_ns_o,
	output reg  [12:0] lock_count_o,
	output reg  [2:0]  lp_flags_o,
	output reg  [2:0]  modulator_order_o,
	output reg         dither_enable_o,
	output reg  [2:0]  cal_slots_o,
	output reg  [8:0]  cal_divider_o,
	output reg         frame_read_o
);

	// ************************************************************
	// input synchronisers and edge detect
	// ************************************************************
	reg [1:0] sck_sync_q;
	reg [1:0] sdi_sync_q;
	reg [1:0] le_sync_q;
	reg       sck_prev_q;
	reg       le_prev_q;
	wire      sck_rise = sck_sync_q[1] & ~sck_prev_q;
	wire      le_rise  = le_sync_q[1] & ~le_prev_q;

	always @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			sck_sync_q <= 2'h0;
			sdi_sync_q <= 2'h0;
			le_sync_q  <= 2'h0;
			sck_prev_q <= 1'b0;
			le_prev_q  <= 1'b0;
		end
		else
		begin
			sck_sync_q <= {sck_sync_q[0], ser_clk_i};
			sdi_sync_q <= {sdi_sync_q[0], ser_data_i};
			le_sync_q  <= {le_sync_q[0], latch_en_i};
			sck_prev_q <= sck_sync_q[1];
			le_prev_q  <= le_sync_q[1];
		end
	end

	// ************************************************************
	// shift register and frame decode
	// ************************************************************
	reg  [31:0] shift_q;
	reg  [5:0]  bit_cnt_q;
	reg  [26:0] sh_reflk_q;
	reg         sh_reflk_pend_q;
	wire [3:0]  fr_addr  = shift_q[`PSCR_ADDR_MSB:`PSCR_ADDR_LSB];
	wire [26:0] fr_data  = shift_q[26:0];
	wire        fr_ok    = le_rise && (bit_cnt_q == 6'h20); // [RL23]
	wire        fr_write = fr_ok & ~shift_q[`PSCR_MODE_BIT];

	always @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			shift_q   <= 32'h0;
			bit_cnt_q <= 6'h0;
		end
		else if (le_rise)
			bit_cnt_q <= 6'h0;
		else if (sck_rise)
		begin
			shift_q <= {shift_q[30:0], sdi_sync_q[1]}; // [RL24]
			if (bit_cnt_q != 6'h3f)
				bit_cnt_q <= bit_cnt_q + 6'h01;
		end
	end

	// ************************************************************
	// register storage
	// ************************************************************
	// only the leakage/reference register honours the shadow bit here
	always @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			master_register_o                  <= `PSCR_RST_ZERO;
			reference_and_leakage_control_o    <= `PSCR_RST_REFLEAK;
			lock_and_oscillator_settings_o     <= `PSCR_RST_LOCKOSC;
			low_power_control_o                <= `PSCR_RST_ZERO;
			calibrator_and_modulator_control_o <= `PSCR_RST_ZERO;
			fast_lock_and_output_pin_control_o <= `PSCR_RST_ZERO;
			sh_reflk_q                         <= `PSCR_RST_ZERO;
			sh_reflk_pend_q                    <= 1'b0;
			frame_read_o                       <= 1'b0;
		end
		else
		begin
			frame_read_o <= fr_ok & shift_q[`PSCR_MODE_BIT];
			if (fr_write)
			begin
				case (fr_addr)
					`PSCR_ADDR_MASTER:
					begin
						master_register_o <= fr_data;
						if (sh_reflk_pend_q)
						begin
							reference_and_leakage_control_o <= sh_reflk_q; // [RL1]
							sh_reflk_pend_q                 <= 1'b0;
						end
					end
					`PSCR_ADDR_REFLEAK:
					begin
						if (fr_data[`PSCR_SHADOW_BIT])
						begin
							sh_reflk_q      <= fr_data; // [RL1]
							sh_reflk_pend_q <= 1'b1;
						end
						else
							reference_and_leakage_control_o <= fr_data; // [RL25]
					end
					`PSCR_ADDR_LOCKOSC:  lock_and_oscillator_settings_o     <= fr_data; // [RL25]
					`PSCR_ADDR_LOWPWR:   low_power_control_o                <= fr_data;
					`PSCR_ADDR_CALMOD:   calibrator_and_modulator_control_o <= fr_data;
					`PSCR_ADDR_FASTLOCK: fast_lock_and_output_pin_control_o <= fr_data;
					default:             frame_read_o                       <= 1'b0;
				endcase
			end
		end
	end

	// ************************************************************
	// field decode
	// ************************************************************
	function [12:0] lock_count_f;
		input [2:0] code;
		begin
			case (code)
				3'h0:    lock_count_f = 13'h0004;
				3'h1:    lock_count_f = 13'h0008;
				3'h2:    lock_count_f = 13'h0010;
				3'h3:    lock_count_f = 13'h0040;
				3'h4:    lock_count_f = 13'h0100;
				3'h5:    lock_count_f = 13'h0400;
				3'h6:    lock_count_f = 13'h0800;
				default: lock_count_f = 13'h1000;
			endcase
		end
	endfunction

	// ratio in half units: 4=doubled, 2=direct, 1=div2, 0=div4 marker
	function [2:0] ref_path_f;
		input [1:0] code;
		begin
			case (code)
				2'h0:    ref_path_f = 3'h2;
				2'h1:    ref_path_f = 3'h4;
				2'h2:    ref_path_f = 3'h1;
				default: ref_path_f = 3'h0;
			endcase
		end
	endfunction

	function [2:0] mod_order_f;
		input [1:0] code;
		begin
			case (code)
				2'h0:    mod_order_f = 3'h3;
				2'h1:    mod_order_f = 3'h2;
				2'h2:    mod_order_f = 3'h1;
				default: mod_order_f = 3'h4;
			endcase
		end
	endfunction

	// 31 x 20 uA = 620 still fits ten bits
	function [9:0] leak_ua_f;
		input [4:0] code;
		input       dbl;
		begin
			leak_ua_f = {5'h0, code} * (dbl ? 10'd20 : 10'd10);
		end
	endfunction

	function [4:0] lock_window_f;
		input [2:0] code;
		begin
			lock_window_f = {1'b0, code, 1'b0} + 5'h02;
		end
	endfunction

	function [8:0] cal_div_f;
		input [8:0] code;
		begin
			cal_div_f = (code == 9'h0) ? `PSCR_CALDIV_MAX : code;
		end
	endfunction

	wire [26:0] rl = reference_and_leakage_control_o;
	wire [26:0] lo = lock_and_oscillator_settings_o;
	wire [26:0] cm = calibrator_and_modulator_control_o;
	wire        locked_raw = loop_locked_i;

	// registered so downstream analog controls see glitch-free levels
	always @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			chip_power_down_o         <= 1'b0;
			leak_current_ua_o         <= 10'h0;
			leak_source_o             <= 1'b0;
			down_split_level_o        <= 2'h0;
			delay_feedback_o          <= 1'b0;
			delay_reference_o         <= 1'b0;
			ref_path_mult_o           <= 3'h2;
			ref_divider_o             <= 13'h0001;
			internal_osc_enable_o     <= 1'b1;
			external_buffer_enable_o  <= 1'b0;
			gain_compensation_o       <= 1'b1;
			detector_inverted_o       <= 1'b0;
			reference_buffer_select_o <= 2'h1;
			rf_output_enable_o        <= 1'b1;
			lock_indicator_o          <= 1'b0;
			lock_window_ns_o          <= 5'h02;
			lock_count_o              <= 13'h0004;
			lp_flags_o                <= 3'h0;
			modulator_order_o         <= 3'h3;
			dither_enable_o           <= 1'b0;
			cal_slots_o               <= 3'h1;
			cal_divider_o             <= `PSCR_CALDIV_MAX;
		end
		else
		begin
			chip_power_down_o  <= rl[`PSCR_PD_BIT]; // [RL2]
			leak_current_ua_o  <= leak_ua_f(rl[23:19], rl[24]); // [RL3]
			leak_source_o      <= rl[18]; // [RL4]
			down_split_level_o <= rl[17] ?
				master_register_o[`PSCR_DETECTOR_DELAY_VALUE_MSB:`PSCR_DETECTOR_DELAY_VALUE_LSB] : 2'h0; // [RL5]
			delay_feedback_o   <= (rl[16:15] == 2'h1); // [RL6]
			delay_reference_o  <= (rl[16:15] == 2'h2); // [RL6]
			ref_path_mult_o           <= ref_path_f(rl[14:13]); // [RL7]
			ref_divider_o             <= rl[12:0]; // [RL8]
			external_buffer_enable_o  <= lo[19] & ~rl[`PSCR_PD_BIT]; // [RL9]
			internal_osc_enable_o     <= ~lo[19] & ~rl[`PSCR_PD_BIT]; // [RL9] [RL2]
			gain_compensation_o       <= ~lo[11]; // [RL12]
			detector_inverted_o       <= lo[10]; // [RL13]
			reference_buffer_select_o <= lo[9:8]; // [RL14]
			rf_output_enable_o <= ~rl[`PSCR_PD_BIT] & ~(lo[7] & ~locked_raw); // [RL15] [RL2]
			lock_indicator_o   <= locked_raw ^ lo[6]; // [RL16]
			lock_window_ns_o   <= lock_window_f(lo[5:3]); // [RL17]
			lock_count_o       <= lock_count_f(lo[2:0]); // [RL18]
			lp_flags_o         <= {low_power_control_o[4], low_power_control_o[2],
				low_power_control_o[0]}; // [RL19]
			modulator_order_o <= mod_order_f(cm[23:22]); // [RL20]
			dither_enable_o <= cm[26]; // [RL20]
			cal_slots_o     <= {1'b0, cm[11:10]} + 3'h1 + (cm[9] ? 3'h2 : 3'h0); // [RL21]
			cal_divider_o   <= cal_div_f(cm[8:0]); // [RL22]
		end
	end

endmodule // pscr_config_bank

//--- bench/pscr_config_bank_properties.sv
// pscr_config_bank_properties.sv: port-level checks on the synth config bank
// assumes: bound to pscr_config_bank; decodes trail register contents by one clock
module pscr_config_bank_properties
(
	input wire logic        core_clk_i,
	input wire logic        reset_i,
	input wire logic        loop_locked_i,
	input wire logic [26:0] master_register_o,
	input wire logic [26:0] reference_and_leakage_control_o,
	input wire logic [26:0] lock_and_oscillator_settings_o,
	input wire logic [26:0] calibrator_and_modulator_control_o,
	input wire logic        chip_power_down_o,
	input wire logic [9:0]  leak_current_ua_o,
	input wire logic [1:0]  down_split_level_o,
	input wire logic [2:0]  ref_path_mult_o,
	input wire logic [12:0] ref_divider_o,
	input wire logic        internal_osc_enable_o,
	input wire logic        external_buffer_enable_o,
	input wire logic        rf_output_enable_o,
	input wire logic        lock_indicator_o,
	input wire logic [4:0]  lock_window_ns_o,
	input wire logic [12:0] lock_count_o,
	input wire logic [2:0]  cal_slots_o,
	input wire logic [8:0]  cal_divider_o
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [26:0] r3 = reference_and_leakage_control_o;
	wire [26:0] r4 = lock_and_oscillator_settings_o;
	wire [26:0] r6 = calibrator_and_modulator_control_o;
	localparam int RP[4] = '{2, 4, 1, 0};
	localparam int LC[8] = '{4, 8, 16, 64, 256, 1024, 2048, 4096};
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	chk_pd_osc_off: assert property (chip_power_down_o |-> !internal_osc_enable_o
		&& !external_buffer_enable_o && !rf_output_enable_o) else $error("active in power down");
	chk_leak_scale: assert property (leak_current_ua_o ==
		$past(r3[23:19]) * ($past(r3[24]) ? 20 : 10)) else $error("leak current wrong");
	chk_split_level: assert property (down_split_level_o ==
		($past(r3[17]) ? $past(master_register_o[20:19]) : 2'h0)) else $error("split level");
	chk_ref_path: assert property (ref_path_mult_o == RP[$past(r3[14:13])])
		else $error("ref path wrong");
	chk_ref_divider: assert property (ref_divider_o == $past(r3[12:0]))
		else $error("ref divider wrong");
	chk_ext_osc: assert property (!chip_power_down_o |-> external_buffer_enable_o ==
		$past(r4[19]) && internal_osc_enable_o != $past(r4[19])) else $error("osc select");
	chk_mute_unlock: assert property (rf_output_enable_o == !($past(r3[25]) ||
		$past(r4[7]) && !$past(loop_locked_i))) else $error("rf mute wrong");
	chk_lock_polarity: assert property (lock_indicator_o ==
		($past(loop_locked_i) ^ $past(r4[6]))) else $error("lock level wrong");
	chk_lock_window: assert property (lock_window_ns_o == 2 * ($past(r4[5:3]) + 1))
		else $error("lock window wrong");
	chk_lock_count: assert property (lock_count_o == LC[$past(r4[2:0])])
		else $error("lock count wrong");
	chk_cal_slots: assert property (cal_slots_o ==
		$past(r6[11:10]) + 1 + ($past(r6[9]) ? 2 : 0)) else $error("cal slots wrong");
	chk_cal_divider: assert property (cal_divider_o ==
		($past(r6[8:0]) == 0 ? 9'h1ff : $past(r6[8:0]))) else $error("cal divider wrong");
endmodule // pscr_config_bank_properties

bind pscr_config_bank pscr_config_bank_properties i_chk (.*);

//--- bench/pscr_host_model.sv
// pscr_host_model.sv: serial host that frames 32-bit words into the bank
// assumes: bit period is eight core clocks (64 ns); serial clock idles low
module pscr_host_model
(
	input  wire logic core_clk_i,
	output logic      ser_clk_o,
	output logic      ser_data_o,
	output logic      latch_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
		latch_en_o = 1'b0;
	end
	task automatic send(input logic [31:0] word, input int nbits);
		for (int i = 0; i < nbits; i++)
		begin
			@(posedge core_clk_i) ser_data_o <= word[31 - i];
			repeat (3) @(posedge core_clk_i);
			ser_clk_o <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			ser_clk_o <= 1'b0;
		end
		repeat (2) @(posedge core_clk_i);
		latch_en_o <= 1'b1;
		// released data line must not keep showing the last bit
		ser_data_o <= ~ser_data_o;
		repeat (4) @(posedge core_clk_i);
		latch_en_o <= 1'b0;
	endtask
endmodule // pscr_host_model

//--- bench/testbench.sv
// testbench.sv: self-checking bench for the synth config bank
// assumes: host model drives the serial pins; checker binds itself
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic loop_locked_i = 1'b0;
	wire  ser_clk;
	wire  ser_data;
	wire  latch_en;
	int   n_mismatch = 0;
	int   checked = 0;
	int   n_reads = 0;
	always #4 core_clk_i = ~core_clk_i;
	pscr_host_model i_host (.core_clk_i(core_clk_i), .ser_clk_o(ser_clk),
		.ser_data_o(ser_data), .latch_en_o(latch_en));
	pscr_config_bank i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ser_clk_i(ser_clk),
		.ser_data_i(ser_data), .latch_en_i(latch_en), .loop_locked_i(loop_locked_i),
		.master_register_o(), .reference_and_leakage_control_o(),
		.lock_and_oscillator_settings_o(), .low_power_control_o(),
		.calibrator_and_modulator_control_o(), .fast_lock_and_output_pin_control_o(),
		.chip_power_down_o(), .leak_current_ua_o(), .leak_source_o(), .down_split_level_o(),
		.delay_feedback_o(), .delay_reference_o(), .ref_path_mult_o(), .ref_divider_o(),
		.internal_osc_enable_o(), .external_buffer_enable_o(), .gain_compensation_o(),
		.detector_inverted_o(), .reference_buffer_select_o(), .rf_output_enable_o(),
		.lock_indicator_o(), .lock_window_ns_o(), .lock_count_o(), .lp_flags_o(),
		.modulator_order_o(), .dither_enable_o(), .cal_slots_o(), .cal_divider_o(),
		.frame_read_o());
	always @(posedge core_clk_i) if (i_dut.frame_read_o === 1'b1) n_reads++;
	task automatic check(input logic [26:0] got, input logic [26:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// register lands three clocks after latch, its decode four; wait twice that
	task automatic frame(input logic [31:0] w, input int n);
		i_host.send(w, n);
		repeat (4) @(posedge core_clk_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [26:0] d);
		frame({1'b0, a, d}, 32);
	endtask
	task automatic t_shadow;
		check(i_dut.ref_divider_o, 27'h1);
		// doubling is only legal on a single-ended reference, so select that first
		wr(4'h4, 27'h0001300);
		check(i_dut.reference_buffer_select_o, 27'h3);
		wr(4'h3, 27'h5febfff);
		check(i_dut.reference_and_leakage_control_o, 27'h1);
		wr(4'h0, 27'h0180000);
		check(i_dut.reference_and_leakage_control_o, 27'h5febfff);
		check(i_dut.master_register_o, 27'h0180000);
		check(i_dut.down_split_level_o, 27'h3);
		check(i_dut.leak_current_ua_o, 27'd620);
		check(i_dut.leak_source_o, 27'h1);
		check({i_dut.delay_reference_o, i_dut.delay_feedback_o}, 27'h1);
		check(i_dut.ref_path_mult_o, 27'h4);
		check(i_dut.ref_divider_o, 27'h1fff);
		wr(4'h3, 27'h2000001);
		check(i_dut.reference_and_leakage_control_o, 27'h2000001);
		check({i_dut.chip_power_down_o, i_dut.internal_osc_enable_o}, 27'h2);
		check(i_dut.down_split_level_o, 27'h0);
		check(i_dut.ref_path_mult_o, 27'h2);
		wr(4'h3, 27'h4190001);
		check(i_dut.chip_power_down_o, 27'h1);
		wr(4'h0, 27'h0);
		check(i_dut.leak_current_ua_o, 27'd30);
		check({i_dut.delay_reference_o, i_dut.delay_feedback_o}, 27'h2);
	endtask
	task automatic t_lock;
		int lc[8] = '{4, 8, 16, 64, 256, 1024, 2048, 4096};
		for (int k = 0; k < 8; k++)
		begin
			@(posedge core_clk_i) loop_locked_i <= k[1];
			// amplitude 0 and calibrator mode 1 suit either core supply
			wr(4'h4, {7'h0, k[0], 6'h0, 1'b1, k[1], k[2], 2'(k % 3 + 1), 1'b1, k[0],
				k[2:0], k[2:0]});
			check(i_dut.lock_count_o, lc[k]);
			check(i_dut.lock_window_ns_o, 2 * k + 2);
			check(i_dut.lock_indicator_o, k[1] ^ k[0]);
			check(i_dut.rf_output_enable_o, k[1]);
			check(i_dut.external_buffer_enable_o, k[0]);
			check(i_dut.gain_compensation_o, !k[1]);
			check(i_dut.detector_inverted_o, k[2]);
			check(i_dut.reference_buffer_select_o, k % 3 + 1);
		end
	endtask
	task automatic t_cal;
		int mo[4] = '{3, 2, 1, 4};
		for (int k = 0; k < 4; k++)
		begin
			wr(4'h5, {22'h0, k[0], 1'b0, k[1], 1'b0, k[0] ^ k[1]});
			wr(4'h6, {k[0], 2'h0, k[1:0], 10'h0, k[1:0], k[0], 9'(k)});
			check(i_dut.lp_flags_o, {k[0], k[1], k[0] ^ k[1]});
			check({i_dut.dither_enable_o, i_dut.modulator_order_o}, mo[k] + 8 * k[0]);
			check(i_dut.cal_slots_o, k + 1 + 2 * k[0]);
			check(i_dut.cal_divider_o, (k == 0) ? 511 : k);
		end
	endtask
	task automatic t_refused;
		frame({1'b0, 4'h5, 27'h0}, 31);
		check(i_dut.low_power_control_o, 27'h14);
		frame({1'b1, 4'h5, 27'h7ffffff}, 32);
		check({i_dut.low_power_control_o, n_reads[0]}, 27'h29);
		wr(4'h7, 27'h1a5a5a5);
		check(i_dut.fast_lock_and_output_pin_control_o, 27'h1a5a5a5);
		// unmapped address whose low bits match the calibrator's; full four-bit decode leaves that register unwritten
		wr(4'he, 27'h7ffffff);
		check(i_dut.calibrator_and_modulator_control_o, 27'h4c00e03);
	endtask
	initial
	begin
		repeat (90000) @(posedge core_clk_i);
		n_mismatch++;
		report_and_stop();
	end
	initial
	begin
		repeat (12) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
		t_shadow();
		t_lock();
		t_cal();
		t_refused();
		report_and_stop();
	end
endmodule // testbench
